// *** core/phy_cfg_regs.sv ***
// APB register bank carrying PHY setup words into the memory clock domain
//
// The APB register port was decided locally.
`timescale 1ns/1ps

// Function
// R1: Registers decoded within one 4KB page
// R2: Setup word A write-only; reads undefined
// R3: Software writes fixed init word to A
// R4: Software keeps non-range bits of A fixed
// R5: Setup word B write-only, resets 0x008A28A2
// R6: Setup word C write-only, no assumed value
// R7: Link state read-only, reads zero after reset
// R8: Setup words drive dedicated PHY outputs
// R9: Bus side core clock, PHY side memory clock
// R10: Range field encodes memory clock band
// R11: Link state 16 bits, reads zero
// R12: Outputs update whole after domain crossing
module phy_cfg_regs
  import phy_cfg_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [31:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        mem_clk_in,
  input  wire logic        mem_rst_in,
  output logic [31:0]      phy_setup_word_a_out,
  output logic [31:0]      phy_setup_word_b_out,
  output logic [31:0]      phy_setup_word_c_out,
  output logic [2:0]       mem_clock_range_select_out,
  output logic             mem_clock_range_valid_out
);

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  logic [11:0] page_ofs;
  logic        in_page;
  logic        hit_state;
  logic        hit_a;
  logic        hit_b;
  logic        hit_c;
  logic        hit_any;
  logic        setup_phase;
  logic        any_busy;
  logic        wr_ok;
  logic        busy_a;
  logic        busy_b;
  logic        busy_c;

  // Only the page base bits and word offset qualify a hit
  assign page_ofs  = paddr_in[CFG_PAGE_ADDR_BITS-1:0];
  assign in_page   = (paddr_in[31:CFG_PAGE_ADDR_BITS] ==
                      CFG_PAGE_BASE[31:CFG_PAGE_ADDR_BITS]);     // R1
  assign hit_state = in_page && (page_ofs == OFS_LINK_STATE);
  assign hit_a     = in_page && (page_ofs == OFS_SETUP_A);
  assign hit_b     = in_page && (page_ofs == OFS_SETUP_B);
  assign hit_c     = in_page && (page_ofs == OFS_SETUP_C);
  assign hit_any   = hit_state || hit_a || hit_b || hit_c;
  assign any_busy  = busy_a || busy_b || busy_c;

  // ----------------------------------------------------------------------
  // APB handshake
  // ----------------------------------------------------------------------
  // A write waits while a previous word is still crossing, which stalls the
  // master instead of tearing a word mid-flight.
  assign setup_phase = psel_in && !penable_in;
  assign wr_ok       = pwrite_in && !any_busy;

  logic        load_a;
  logic        load_b;
  logic        load_c;
  logic [31:0] rd_word;
  logic        err_word;

  assign load_a = psel_in && penable_in && !pready_out && wr_ok && hit_a;
  assign load_b = psel_in && penable_in && !pready_out && wr_ok && hit_b;
  assign load_c = psel_in && penable_in && !pready_out && wr_ok && hit_c;

  // Write-only words read back a fixed filler; link state is all zero
  assign rd_word  = hit_state ? {16'h0000, LINK_STATE_RESET}   // R7 R11
                              : WO_READ_VALUE;                 // R2
  // Writes to the read-only state word and unmapped offsets flag an error
  assign err_word = !hit_any || (pwrite_in && hit_state);

  // One wait state minimum: answer one cycle into the access phase
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
      if (psel_in && penable_in && !pready_out && (!pwrite_in || wr_ok)) begin
        pready_out  <= 1'b1;
        pslverr_out <= err_word;
        prdata_out  <= pwrite_in ? 32'h0000_0000 : rd_word;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Crossings into the memory clock domain
  // ----------------------------------------------------------------------
  // Each word crosses as a whole via handshake, so no partial field update
  cfg_word_xfer #(.WIDTH(32), .INIT(SETUP_A_RESET)) u_xfer_a (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .load_in     (load_a),
    .data_in     (pwdata_in),
    .busy_out    (busy_a),
    .mem_clk_in  (mem_clk_in),
    .mem_rst_in  (mem_rst_in),
    .word_out    (phy_setup_word_a_out)           // R8 R9
  );

  cfg_word_xfer #(.WIDTH(32), .INIT(SETUP_B_RESET)) u_xfer_b (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .load_in     (load_b),
    .data_in     (pwdata_in),
    .busy_out    (busy_b),
    .mem_clk_in  (mem_clk_in),
    .mem_rst_in  (mem_rst_in),
    .word_out    (phy_setup_word_b_out)           // R5
  );

  // No meaningful value is assumed; zero is only a safe power-on filler
  cfg_word_xfer #(.WIDTH(32), .INIT(SETUP_C_RESET)) u_xfer_c (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .load_in     (load_c),
    .data_in     (pwdata_in),
    .busy_out    (busy_c),
    .mem_clk_in  (mem_clk_in),
    .mem_rst_in  (mem_rst_in),
    .word_out    (phy_setup_word_c_out)           // R6
  );

  // ----------------------------------------------------------------------
  // Clock range field, memory domain
  // ----------------------------------------------------------------------
  logic [2:0] range_d;
  logic       range_ok_d;

  // Codes with the top bit clear are not a band; valid flags a usable code
  assign range_d    = phy_setup_word_a_out[RANGE_MSB:RANGE_LSB];
  assign range_ok_d = (range_d == RANGE_250_266) || (range_d == RANGE_214_250) ||
                      (range_d == RANGE_200_214) || (range_d == RANGE_125_200); // R10

  always_ff @(posedge mem_clk_in or posedge mem_rst_in) begin
    if (mem_rst_in) begin
      mem_clock_range_select_out <= 3'h0;
      mem_clock_range_valid_out  <= 1'b0;
    end else begin
      mem_clock_range_select_out <= range_d;      // R8
      mem_clock_range_valid_out  <= range_ok_d;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_acc_start;
    psel_in && penable_in && !pready_out;
  endsequence

  chk_ready_one_cycle: assert property (@(posedge core_clk_in) disable iff (rst_in) // R1
    pready_out |=> !pready_out)
    else $error("pready held longer than one cycle");

  chk_state_reads_zero: assert property (@(posedge core_clk_in) disable iff (rst_in) // R7
    (s_acc_start and (!pwrite_in && hit_state)) |=> (pready_out && prdata_out == 32'h0))
    else $error("link state read not zero");

  chk_wo_read_filler: assert property (@(posedge core_clk_in) disable iff (rst_in) // R2
    (s_acc_start and (!pwrite_in && hit_a)) |=> (prdata_out == WO_READ_VALUE))
    else $error("setup word read returned stored contents");

  chk_unmapped_error: assert property (@(posedge core_clk_in) disable iff (rst_in) // R1
    (s_acc_start and (!hit_any && !pwrite_in)) |=> (pready_out && pslverr_out))
    else $error("unmapped access not flagged");

  chk_load_busy: assert property (@(posedge core_clk_in) disable iff (rst_in) // R12
    load_a |=> busy_a)
    else $error("setup word a not held busy after load");

  chk_no_load_busy: assert property (@(posedge core_clk_in) disable iff (rst_in) // R12
    any_busy |-> !(load_a || load_b || load_c))
    else $error("load while crossing in flight");

  chk_busy_bounded: assert property (@(posedge core_clk_in) disable iff (rst_in) // R9
    $rose(busy_b) |-> ##[1:40] !busy_b)
    else $error("setup word b crossing did not complete");

  chk_range_tracks: assert property (@(posedge mem_clk_in) disable iff (mem_rst_in) // R10
    1'b1 |=> (mem_clock_range_select_out == $past(range_d) &&
              mem_clock_range_valid_out == $past(range_d[2])))
    else $error("range select not following word a");

  chk_b_reset: assert property (@(posedge mem_clk_in) disable iff (mem_rst_in) // R5
    $fell(mem_rst_in) |-> phy_setup_word_b_out == SETUP_B_RESET)
    else $error("setup word b reset value wrong");

  // A setup cycle is never answered; the answer needs an access phase
  chk_setup_no_ready: assert property (@(posedge core_clk_in) disable iff (rst_in) // R1
    setup_phase |=> !pready_out)
    else $error("ready raised for a setup cycle");

  // A write arriving while a word is crossing must stall, not answer
  chk_write_stalls: assert property (@(posedge core_clk_in) disable iff (rst_in) // R12
    (s_acc_start and (pwrite_in && any_busy)) |=> !pready_out)
    else $error("write answered while a word was crossing");

  // Valid may only flag one of the four band codes
  chk_valid_has_band: assert property (@(posedge mem_clk_in) disable iff (mem_rst_in) // R10
    mem_clock_range_valid_out |-> mem_clock_range_select_out[2])
    else $error("range valid without a band code");

endmodule : phy_cfg_regs

// *** pkg/phy_cfg_pkg.sv ***
// Package holding offsets, reset values and field layout of the PHY setup registers
package phy_cfg_pkg;

  // ----------------------------------------------------------------------
  // Page placement
  // ----------------------------------------------------------------------
  localparam logic [31:0] CFG_PAGE_BASE      = 32'h100E_0000;
  localparam int          CFG_PAGE_ADDR_BITS = 12;               // 4KB page

  // ----------------------------------------------------------------------
  // Register offsets within the page
  // ----------------------------------------------------------------------
  localparam logic [11:0] OFS_LINK_STATE = 12'h300;
  localparam logic [11:0] OFS_SETUP_A    = 12'h304;
  localparam logic [11:0] OFS_SETUP_B    = 12'h308;
  localparam logic [11:0] OFS_SETUP_C    = 12'h310;

  // ----------------------------------------------------------------------
  // Reset and mandated values
  // ----------------------------------------------------------------------
  localparam logic [31:0] SETUP_A_INIT_WORD  = 32'h7C92_4924;
  localparam logic [31:0] SETUP_A_RESET      = 32'h0000_0000;
  localparam logic [31:0] SETUP_B_RESET      = 32'h008A_28A2;
  localparam logic [31:0] SETUP_C_RESET      = 32'h0000_0000;
  localparam logic [15:0] LINK_STATE_RESET   = 16'h0000;
  localparam logic [31:0] WO_READ_VALUE      = 32'h0000_0000;  // Filler for write-only reads
  localparam int          LINK_STATE_WIDTH   = 16;

  // ----------------------------------------------------------------------
  // Clock range field inside setup word A
  // ----------------------------------------------------------------------
  localparam int          RANGE_LSB          = 24;
  localparam int          RANGE_MSB          = 26;
  localparam logic [2:0]  RANGE_250_266      = 3'h4;
  localparam logic [2:0]  RANGE_214_250      = 3'h5;
  localparam logic [2:0]  RANGE_200_214      = 3'h6;
  localparam logic [2:0]  RANGE_125_200      = 3'h7;

  // ----------------------------------------------------------------------
  // Crossing timing
  // ----------------------------------------------------------------------
  localparam int          SYNC_STAGES        = 3;

endpackage : phy_cfg_pkg

// *** core/cfg_word_xfer.sv ***
// Handshake crossing that carries one register word into the memory clock domain
`timescale 1ns/1ps

module cfg_word_xfer
  import phy_cfg_pkg::*;
#(
  parameter int          WIDTH = 32,
  parameter logic [31:0] INIT  = 32'h0000_0000
) (
  input  wire logic             core_clk_in,
  input  wire logic             rst_in,
  input  wire logic             load_in,      // One-cycle pulse, core domain
  input  wire logic [WIDTH-1:0] data_in,
  output logic                  busy_out,     // Held word still in flight
  input  wire logic             mem_clk_in,
  input  wire logic             mem_rst_in,
  output logic [WIDTH-1:0]      word_out      // Memory-domain copy
);

  // ----------------------------------------------------------------------
  // Core side: hold word, toggle request
  // ----------------------------------------------------------------------
  logic [WIDTH-1:0]       hold_q;
  logic                   req_q;
  logic [SYNC_STAGES-1:0] ack_sync_q;
  logic                   ack_seen;

  // Ack agrees on last two stages before the next word may be taken
  assign ack_seen = (ack_sync_q[SYNC_STAGES-1] == ack_sync_q[SYNC_STAGES-2]) &&
                    (ack_sync_q[SYNC_STAGES-1] == req_q);

  // Hold register is stable while the request is in flight, so no torn word
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      hold_q   <= INIT[WIDTH-1:0];
      req_q    <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      if (load_in) begin
        hold_q   <= data_in;
        req_q    <= ~req_q;
        busy_out <= 1'b1;
      end else if (ack_seen) begin
        busy_out <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Memory side: detect toggle, capture word, echo ack
  // ----------------------------------------------------------------------
  logic [SYNC_STAGES-1:0] req_sync_q;
  logic                   ack_q;
  logic                   req_new;

  assign req_new = (req_sync_q[SYNC_STAGES-1] == req_sync_q[SYNC_STAGES-2]) &&
                   (req_sync_q[SYNC_STAGES-1] != ack_q);

  // Word is captured whole once the request settles
  always_ff @(posedge mem_clk_in or posedge mem_rst_in) begin
    if (mem_rst_in) begin
      req_sync_q <= '0;
      ack_q      <= 1'b0;
      word_out   <= INIT[WIDTH-1:0];
    end else begin
      req_sync_q <= {req_sync_q[SYNC_STAGES-2:0], req_q};
      if (req_new) begin
        word_out <= hold_q;            // R12
        ack_q    <= ~ack_q;
      end
    end
  end

  // Ack returns through three core-domain stages
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_sync_q <= '0;
    end else begin
      ack_sync_q <= {ack_sync_q[SYNC_STAGES-2:0], ack_q};
    end
  end

endmodule : cfg_word_xfer

// *** tb/phy_side_model.sv ***
// Far-side model: memory clock source and memory-domain reset for the PHY side
`timescale 1ns/1ps

module phy_side_model #(
  parameter real HALF_NS = 3.76  // Roughly 133 MHz, no relation to the bus clock
) (
  input  wire logic rst_in,
  output logic      mem_clk_out,
  output logic      mem_rst_out
);
  // ----------------------------------------------------------------------
  // Memory clock
  // ----------------------------------------------------------------------
  logic [1:0] hold_q;

  // Odd start offset keeps the two clock phases apart
  initial begin
    mem_clk_out = 1'b0;
    #1.3;
    forever #(HALF_NS) mem_clk_out = ~mem_clk_out;
  end

  // ----------------------------------------------------------------------
  // Reset: asserted with the bus reset, released two memory edges later
  // ----------------------------------------------------------------------
  always_ff @(posedge mem_clk_out or posedge rst_in) begin
    if (rst_in) hold_q <= 2'b11;
    else        hold_q <= {hold_q[0], 1'b0};
  end
  assign mem_rst_out = hold_q[1];

endmodule : phy_side_model

// *** tb/phy_cfg_regs_bench.sv ***
// Self-checking bench: APB accesses and PHY output checks for the setup registers
`timescale 1ns/1ps

module phy_cfg_regs_bench;
  import phy_cfg_pkg::*;

  // ----------------------------------------------------------------------
  // Signals, clock, design and far side
  // ----------------------------------------------------------------------
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, mem_clk, mem_rst;
  logic        rvalid;
  logic [31:0] paddr, pwdata, prdata, wa, wb, wc, rd, exp_a;
  logic [2:0]  rsel;
  logic        er;
  int          bad_count, cmp_count, cyc;

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  phy_cfg_regs dut (.core_clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .mem_clk_in(mem_clk), .mem_rst_in(mem_rst),
    .phy_setup_word_a_out(wa), .phy_setup_word_b_out(wb), .phy_setup_word_c_out(wc),
    .mem_clock_range_select_out(rsel), .mem_clock_range_valid_out(rvalid));

  phy_side_model far (.rst_in(rst), .mem_clk_out(mem_clk), .mem_rst_out(mem_rst));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic print_verdict();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask : chk

  // One APB transfer; pready, prdata and pslverr are taken at the rising edge that ends it
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 200);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 200) chk("pready", 32'h0000_0001, 32'h0000_0000);
  endtask : apb

  // Waits a bounded time for one PHY word to settle, then compares it
  task automatic settle(input int sel, input logic [31:0] exp);
    logic [31:0] got;
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      got = (sel == 0) ? wa : (sel == 1) ? wb : wc;
      if (got === exp) break;
    end
    chk($sformatf("phy word %0d", sel), exp, got);
  endtask : settle

  // Hang guard, far above the hundred-odd cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    bad_count = 0; cmp_count = 0; cyc = 0;
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 32'h0000_0000; pwdata = 32'h0000_0000;
    repeat (8) @(posedge clk);
    rst <= 1'b0;

    // Reset state of outputs and status register
    settle(1, SETUP_B_RESET);
    chk("range valid", 32'h0, {31'h0, rvalid});
    apb(1'b0, CFG_PAGE_BASE + OFS_LINK_STATE, 32'h0, rd, er);
    chk("link state", {16'h0000, LINK_STATE_RESET}, rd);
    chk("link err", 32'h0, {31'h0, er});
    $display("Test reset done");

    // Each of the four band range codes (4 to 7), other bits kept at the mandated word
    for (int c = 4; c < 8; c++) begin
      exp_a = (SETUP_A_INIT_WORD & 32'hF8FF_FFFF) | (32'(c) << RANGE_LSB);
      apb(1'b1, CFG_PAGE_BASE + OFS_SETUP_A, exp_a, rd, er);
      chk("write a err", 32'h0, {31'h0, er});
      settle(0, exp_a);
      repeat (4) @(negedge clk);
      chk("range code", 32'(c), {29'h0, rsel});
      chk("range valid", 32'h1, {31'h0, rvalid});
      apb(1'b0, CFG_PAGE_BASE + OFS_SETUP_A, 32'h0, rd, er);
      chk("read a", WO_READ_VALUE, rd);
    end
    $display("Test range codes done");

    // Back-to-back writes of B and C, then reads of both
    apb(1'b1, CFG_PAGE_BASE + OFS_SETUP_B, 32'h1234_5678, rd, er);
    apb(1'b1, CFG_PAGE_BASE + OFS_SETUP_C, 32'hA5C3_0F96, rd, er);
    settle(1, 32'h1234_5678);
    settle(2, 32'hA5C3_0F96);
    apb(1'b0, CFG_PAGE_BASE + OFS_SETUP_B, 32'h0, rd, er);
    chk("read b", WO_READ_VALUE, rd);
    apb(1'b0, CFG_PAGE_BASE + OFS_SETUP_C, 32'h0, rd, er);
    chk("read c", WO_READ_VALUE, rd);
    $display("Test words b c done");

    // Refused accesses: read-only status, hole in the page, address off the page
    apb(1'b1, CFG_PAGE_BASE + OFS_LINK_STATE, 32'hFFFF_FFFF, rd, er);
    chk("ro write err", 32'h1, {31'h0, er});
    apb(1'b0, CFG_PAGE_BASE + OFS_LINK_STATE, 32'h0, rd, er);
    chk("link after write", 32'h0, rd);
    apb(1'b1, CFG_PAGE_BASE + 32'h0000_030C, 32'h0, rd, er);
    chk("hole err", 32'h1, {31'h0, er});
    apb(1'b1, CFG_PAGE_BASE + 32'h0000_1304, 32'h0, rd, er);
    chk("off page err", 32'h1, {31'h0, er});
    repeat (20) @(negedge clk);
    chk("word a kept", exp_a, wa);
    $display("Test refusals done");

    // Mid-run reset puts PHY words B and A back to their reset values
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    settle(1, SETUP_B_RESET);
    settle(0, SETUP_A_RESET);
    chk("range valid rst", 32'h0, {31'h0, rvalid});
    $display("Test mid-run reset done");

    print_verdict();
  end

endmodule : phy_cfg_regs_bench
